// ==== core/art_pkg.sv ====
// Summary of operation
// - Wide counter decrements, reloads one tick after zero
// - Wide timer runs from reset with all-ones reload
// - Wide load: high byte, then low byte reloads
// - Wide reload at zero raises reload pulse
// - Reload pulse toggles half-rate even-duty frequency output
// - Low read latches high byte for next read
// - Wide rate is input clock over N+1
// - Late load never cancels a scheduled pulse
// - Software waits half tick after wide load
// - Software uses byte accesses on wide registers
// - Narrow counters decrement, reload one tick after zero
// - Narrow timers idle after reset, reload writable
// - Narrow reload may be written during standby
// - Enable starts counting from reload value at once
// - Active narrow write restarts count from new value
// - Narrow wrap raises pulse and toggles output
// - Disable freezes counter, outputs low, reload kept
// - Narrow counts are never readable
// - Late disable emits an extra pulse at once
// - Late disable stores pulse, replayed on re-enable
// - Software waits half tick after narrow changes
// - Input clock rate per timer is fixed option
// - Narrow rate is input clock over N+1
package art_pkg;

	// ****************************************
	// Timer set layout
	// ****************************************
	localparam int unsigned ART_NUM_TIMERS = 5;
	localparam int unsigned ART_NUM_NARROW = 4;
	localparam int unsigned ART_PRE_W      = 8;

	// Fixed input clock option: pclk cycles per input clock of each timer, wide first.
	localparam int unsigned ART_IN_DIV [ART_NUM_TIMERS] = '{4, 8, 16, 32, 64};
	localparam int unsigned ART_DIV_MAX = 64;

	// Half an input clock of the slowest timer, the settling wait after loads.
	localparam int unsigned ART_SETTLE_CYC = ART_DIV_MAX / 2;

	// ****************************************
	// Device register port
	// ****************************************
	localparam logic [2:0]  ART_A_WIDE_LOW   = 3'h0;
	localparam logic [2:0]  ART_A_WIDE_HIGH  = 3'h1;
	localparam logic [2:0]  ART_A_NARROW0    = 3'h2;
	localparam logic [15:0] ART_WIDE_RST     = 16'hffff;
	localparam logic [7:0]  ART_BYTE_RST     = 8'hff;
	localparam logic [7:0]  ART_NARROW_RST   = 8'h00;

	// ****************************************
	// Controller APB map
	// ****************************************
	localparam logic [7:0] ART_OFS_ENABLE      = 8'h00;
	localparam logic [7:0] ART_OFS_NARROW_LOAD = 8'h04;
	localparam logic [7:0] ART_OFS_WIDE_LOAD   = 8'h08;
	localparam logic [7:0] ART_OFS_WIDE_COUNT  = 8'h0c;
	localparam logic [7:0] ART_OFS_STATUS      = 8'h10;
	localparam int unsigned ART_SETTLED_BIT    = 16;

endpackage

// ==== core/art_if.sv ====
interface art_if
	import art_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn
);
	logic                      reg_wr;
	logic                      reg_rd;
	logic [2:0]                reg_addr;
	logic [7:0]                reg_wdata;
	logic [7:0]                reg_rdata;
	logic [ART_NUM_NARROW-1:0] narrow_en;
	logic [ART_NUM_TIMERS-1:0] irq_src;
	logic [ART_NUM_TIMERS-1:0] freq_out;

	modport dev (
		input  pclk, presetn, reg_wr, reg_rd, reg_addr, reg_wdata, narrow_en,
		output reg_rdata, irq_src, freq_out
	);

	modport ctl (
		input  pclk, presetn, reg_rdata, irq_src, freq_out,
		output reg_wr, reg_rd, reg_addr, reg_wdata, narrow_en
	);
endinterface

// ==== core/art_timer_dev.sv ====
module art_timer_dev
	import art_pkg::*;
(
	// Register port, enables and timer outputs
	art_if.dev bus
);

	// ****************************************
	// State
	// ****************************************
	// A pulse that a late load may no longer cancel waits in sched until the next
	// input clock; one caught by a late disable waits in nstore until the next enable.
	typedef struct packed {
		logic [15:0]                                wcnt;
		logic [15:0]                                wrel;
		logic [7:0]                                 whi_stage;
		logic [7:0]                                 whold;
		logic [7:0]                                 rdata;
		logic [ART_NUM_TIMERS-1:0][ART_PRE_W-1:0]   pre;
		logic [ART_NUM_NARROW-1:0][7:0]             ncnt;
		logic [ART_NUM_NARROW-1:0][7:0]             nrel;
		logic [ART_NUM_NARROW-1:0]                  nen_d;
		logic [ART_NUM_NARROW-1:0]                  nstore;
		logic [ART_NUM_TIMERS-1:0]                  sched;
		logic [ART_NUM_TIMERS-1:0]                  irq;
		logic [ART_NUM_TIMERS-1:0]                  fout;
	} art_dev_s;

	art_dev_s st_r;
	art_dev_s st_nxt;
	logic [ART_NUM_TIMERS-1:0] tick;
	logic [ART_NUM_TIMERS-1:0] late;
	logic [ART_NUM_NARROW-1:0] en_rise;
	logic [ART_NUM_NARROW-1:0] en_fall;
	logic [ART_NUM_NARROW-1:0] nwr_hit;

	// ****************************************
	// Input clock enables
	// ****************************************
	// Every timer shares pclk; its input clock is a one-cycle tick from a free-running
	// prescaler whose length is a fixed option, never a register.
	// The late half of an input clock is the window in which a load can no longer
	// cancel a pending pulse, and in which a disable produces the extra pulse.
	always_comb
	begin
		for (int i = 0; i < ART_NUM_TIMERS; i++)
		begin
			tick[i] = (st_r.pre[i] == ART_PRE_W'(ART_IN_DIV[i] - 1));
			late[i] = (st_r.pre[i] >= ART_PRE_W'(ART_IN_DIV[i] / 2));
		end
		late[0] = late[0] && (st_r.wcnt == 16'h0000);
		for (int i = 0; i < ART_NUM_NARROW; i++)
			late[i + 1] = late[i + 1] && (st_r.ncnt[i] == 8'h00) && st_r.nen_d[i];
	end

	// ****************************************
	// Enable edges and write decode
	// ****************************************
	// The registered copy of each enable marks the cycle in which a timer leaves or
	// enters standby; the count start and the late-disable pulse both hang on it.
	always_comb
	begin
		for (int i = 0; i < ART_NUM_NARROW; i++)
		begin
			en_rise[i] = bus.narrow_en[i] && !st_r.nen_d[i];
			en_fall[i] = !bus.narrow_en[i] && st_r.nen_d[i];
			nwr_hit[i] = bus.reg_wr && (bus.reg_addr == ART_A_NARROW0 + 3'(i));
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic pulse;
		pulse  = 1'b0;
		st_nxt = st_r;

		for (int i = 0; i < ART_NUM_TIMERS; i++)
			st_nxt.pre[i] = tick[i] ? '0 : st_r.pre[i] + 1'b1;

		// Wide timer never stops. Its pulse is rewritten only on ticks, so it stands
		// for one whole input clock and then drops unless the next tick reloads again.
		if (tick[0])
		begin
			pulse = (st_r.wcnt == 16'h0000) || st_r.sched[0];
			st_nxt.irq[0]   = pulse;
			st_nxt.fout[0]  = st_r.fout[0] ^ pulse;
			st_nxt.sched[0] = 1'b0;
			st_nxt.wcnt     = (st_r.wcnt == 16'h0000) ? st_r.wrel
			                                          : st_r.wcnt - 1'b1;
		end

		for (int i = 0; i < ART_NUM_NARROW; i++)
		begin
			// Standby holds the counter. A pulse stored by a late disable comes back as
			// the scheduled one after the next enable, whatever was loaded meanwhile.
			st_nxt.nen_d[i] = bus.narrow_en[i];
			if (en_rise[i])
			begin
				st_nxt.ncnt[i]      = st_r.nrel[i];
				st_nxt.sched[i + 1] = st_r.nstore[i];
				st_nxt.nstore[i]    = 1'b0;
			end
			else if (en_fall[i])
			begin
				st_nxt.fout[i + 1] = 1'b0;
				st_nxt.irq[i + 1]  = late[i + 1];
				st_nxt.nstore[i]   = late[i + 1] | st_r.sched[i + 1];
				st_nxt.sched[i + 1] = 1'b0;
			end
			else if (!st_r.nen_d[i])
			begin
				// Counter frozen; a pending extra pulse ends with the input clock.
				if (tick[i + 1])
					st_nxt.irq[i + 1] = 1'b0;
			end
			else if (tick[i + 1])
			begin
				pulse = (st_r.ncnt[i] == 8'h00) || st_r.sched[i + 1];
				st_nxt.irq[i + 1]   = pulse;
				st_nxt.fout[i + 1]  = st_r.fout[i + 1] ^ pulse;
				st_nxt.sched[i + 1] = 1'b0;
				st_nxt.ncnt[i] = (st_r.ncnt[i] == 8'h00) ? st_r.nrel[i]
				                                         : st_r.ncnt[i] - 1'b1;
			end
		end

		// ****************************************
		// Register port
		// ****************************************
		if (bus.reg_wr)
		begin
			if (bus.reg_addr == ART_A_WIDE_HIGH)
				st_nxt.whi_stage = bus.reg_wdata;
			else if (bus.reg_addr == ART_A_WIDE_LOW)
			begin
				st_nxt.wrel = {st_r.whi_stage, bus.reg_wdata};
				st_nxt.wcnt = {st_r.whi_stage, bus.reg_wdata};
				if (late[0] && !tick[0])
					st_nxt.sched[0] = 1'b1;
			end
			else
			begin
				// In standby a load lands only in the reload register and waits for the
				// enable; a running timer restarts from it at once.
				for (int i = 0; i < ART_NUM_NARROW; i++)
				begin
					if (nwr_hit[i])
					begin
						st_nxt.nrel[i] = bus.reg_wdata;
						if (st_r.nen_d[i] && bus.narrow_en[i])
						begin
							st_nxt.ncnt[i] = bus.reg_wdata;
							if (late[i + 1] && !tick[i + 1])
								st_nxt.sched[i + 1] = 1'b1;
						end
					end
				end
			end
		end

		// Freezing the high byte on the low read keeps a time stamp consistent even
		// when the count borrows between the two reads.
		if (bus.reg_rd)
		begin
			if (bus.reg_addr == ART_A_WIDE_LOW)
			begin
				st_nxt.rdata = st_r.wcnt[7:0];
				st_nxt.whold = st_r.wcnt[15:8];
			end
			else if (bus.reg_addr == ART_A_WIDE_HIGH)
				st_nxt.rdata = st_r.whold;
			else
				st_nxt.rdata = 8'h00;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Only constants enter the reset branch. The wide timer leaves reset loaded with
	// all ones, so its first pulse is a full longest period away.
	always_ff @(posedge bus.pclk or negedge bus.presetn)
	begin
		if (!bus.presetn)
		begin
			st_r           <= '0;
			st_r.wcnt      <= ART_WIDE_RST;
			st_r.wrel      <= ART_WIDE_RST;
			st_r.whi_stage <= ART_BYTE_RST;
			st_r.whold     <= ART_BYTE_RST;
			st_r.nrel      <= {ART_NUM_NARROW{ART_NARROW_RST}};
		end
		else
			st_r <= st_nxt;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Every output comes straight from a flop, so the interrupt controller and the
	// pins never see a decode glitch.
	assign bus.reg_rdata = st_r.rdata;
	assign bus.irq_src   = st_r.irq;
	assign bus.freq_out  = st_r.fout;

endmodule

// ==== core/art_timer_ctl.sv ====
module art_timer_ctl
	import art_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Timer set
	art_if.ctl               tmr
);

	typedef enum logic [2:0] {
		CS_IDLE, CS_WR_LO, CS_RD_HI, CS_RD_CAP, CS_RD_END, CS_DONE
	} art_cs_e;

	typedef struct packed {
		art_cs_e                   cs;
		logic                      wr;
		logic                      rd;
		logic [2:0]                addr;
		logic [7:0]                wdata;
		logic [ART_NUM_NARROW-1:0] en;
		logic [31:0]               rdata;
		logic                      err;
		logic [15:0]               settle;
	} art_ctl_s;

	art_ctl_s st_r;
	art_ctl_s st_nxt;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic acc;
		acc    = psel && penable;
		st_nxt = st_r;
		st_nxt.wr = 1'b0;
		st_nxt.rd = 1'b0;
		if (st_r.settle != 16'h0000)
			st_nxt.settle = st_r.settle - 1'b1;

		case (st_r.cs)
			CS_IDLE:
			begin
				if (acc)
				begin
					st_nxt.cs    = CS_DONE;
					st_nxt.err   = 1'b0;
					st_nxt.rdata = '0;
					if (paddr == ART_OFS_ENABLE)
					begin
						if (pwrite)
						begin
							st_nxt.en     = pwdata[ART_NUM_NARROW-1:0];
							st_nxt.settle = 16'(ART_SETTLE_CYC);
						end
						st_nxt.rdata[ART_NUM_NARROW-1:0] = st_r.en;
					end
					else if (paddr == ART_OFS_NARROW_LOAD)
					begin
						if (pwrite)
						begin
							st_nxt.wr     = 1'b1;
							st_nxt.addr   = ART_A_NARROW0 + {1'b0, pwdata[9:8]};
							st_nxt.wdata  = pwdata[7:0];
							st_nxt.settle = 16'(ART_SETTLE_CYC);
						end
					end
					else if (paddr == ART_OFS_WIDE_LOAD)
					begin
						if (pwrite)
						begin
							st_nxt.wr    = 1'b1;
							st_nxt.addr  = ART_A_WIDE_HIGH;
							st_nxt.wdata = pwdata[15:8];
							st_nxt.cs    = CS_WR_LO;
						end
					end
					else if (paddr == ART_OFS_WIDE_COUNT)
					begin
						if (!pwrite)
						begin
							st_nxt.rd   = 1'b1;
							st_nxt.addr = ART_A_WIDE_LOW;
							st_nxt.cs   = CS_RD_HI;
						end
					end
					else if (paddr == ART_OFS_STATUS)
					begin
						st_nxt.rdata[ART_NUM_TIMERS-1:0] = tmr.freq_out;
						st_nxt.rdata[ART_SETTLED_BIT]    = (st_r.settle == 16'h0000);
					end
					else
						st_nxt.err = 1'b1;
				end
			end
			CS_WR_LO:
			begin
				st_nxt.wr     = 1'b1;
				st_nxt.addr   = ART_A_WIDE_LOW;
				st_nxt.wdata  = pwdata[7:0];
				st_nxt.settle = 16'(ART_SETTLE_CYC);
				st_nxt.cs     = CS_DONE;
			end
			CS_RD_HI:
			begin
				st_nxt.rd   = 1'b1;
				st_nxt.addr = ART_A_WIDE_HIGH;
				st_nxt.cs   = CS_RD_CAP;
			end
			// Read data stands on the device port one cycle after its strobe, so each
			// byte is taken two states after the state that issued its read.
			CS_RD_CAP:
			begin
				st_nxt.rdata[7:0] = tmr.reg_rdata;
				st_nxt.cs         = CS_RD_END;
			end
			CS_RD_END:
			begin
				st_nxt.rdata[15:8] = tmr.reg_rdata;
				st_nxt.cs          = CS_DONE;
			end
			CS_DONE:
				st_nxt.cs = CS_IDLE;
			default:
				st_nxt.cs = CS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign pready        = (st_r.cs == CS_DONE);
	assign prdata        = st_r.rdata;
	assign pslverr       = st_r.err && (st_r.cs == CS_DONE);
	assign tmr.reg_wr    = st_r.wr;
	assign tmr.reg_rd    = st_r.rd;
	assign tmr.reg_addr  = st_r.addr;
	assign tmr.reg_wdata = st_r.wdata;
	assign tmr.narrow_en = st_r.en;

endmodule

// ==== sim/art_assertions.sv ====
// ****************************************
// Timer set interface checker
// ****************************************
module art_assertions
	import art_pkg::*;
(
	// Clock and reset
	input wire logic                      pclk,
	input wire logic                      presetn,
	// Device register port
	input wire logic                      reg_wr,
	input wire logic                      reg_rd,
	input wire logic [2:0]                reg_addr,
	input wire logic [7:0]                reg_wdata,
	input wire logic [7:0]                reg_rdata,
	// Timer controls and outputs
	input wire logic [ART_NUM_NARROW-1:0] narrow_en,
	input wire logic [ART_NUM_TIMERS-1:0] irq_src,
	input wire logic [ART_NUM_TIMERS-1:0] freq_out
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wide_load;
		reg_wr && reg_addr == 3'h1 && reg_wdata == 8'h00
		##1 reg_wr && reg_addr == 3'h0 && reg_wdata == 8'h03;
	endsequence

	a_load_order: assert property (reg_wr && reg_addr == 3'h1 |=> reg_wr && reg_addr == 3'h0)
		else $error("wide high byte not followed by low byte");
	a_read_order: assert property (reg_rd && reg_addr == 3'h0 |=> reg_rd && reg_addr == 3'h1)
		else $error("wide low read not followed by high read");
	// A reload of three gives sixteen cycles; the range allows for the divider phase.
	a_load_takes: assert property (s_wide_load |-> ##[1:24] $rose(irq_src[0]))
		else $error("wide load did not restart the count");
	a_wide_pulse_len: assert property ($rose(irq_src[0]) |-> irq_src[0][*4] ##1 !irq_src[0])
		else $error("wide pulse not one input clock long");
	a_narrow_pulse_len: assert property ($rose(irq_src[1]) ##1 narrow_en[0][*8]
		|-> !irq_src[1] && $past(irq_src[1]))
		else $error("narrow pulse not one input clock long");
	a_standby_quiet: assert property ((!narrow_en[0])[*8] ##1 (!narrow_en[0])[*4] |-> !irq_src[1])
		else $error("narrow pulse while in standby");

	for (genvar i = 0; i < ART_NUM_TIMERS; i++)
	begin : g_all
		a_freq_cause: assert property ($rose(freq_out[i]) |-> irq_src[i])
			else $error("frequency output rose without reload");
	end
	for (genvar i = 0; i < ART_NUM_NARROW; i++)
	begin : g_narrow
		a_idle_out_low: assert property (!narrow_en[i] |=> !freq_out[i+1])
			else $error("narrow output high while disabled");
	end
endmodule

// ==== sim/test_auto_reload_timer_set.sv ====
module test_auto_reload_timer_set
	import art_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [31:0] seed    = 32'h000070a7;
	logic [31:0] q;
	logic        e;
	int          err_total  = 0;
	int          n_compared = 0;
	int          n;
	int          gap;
	int          nar_n[$];

	always #5 pclk = ~pclk;

	art_if tif (.pclk(pclk), .presetn(presetn));
	art_timer_dev i_art_timer_dev (.bus(tif.dev));
	art_timer_ctl i_art_timer_ctl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .tmr(tif.ctl));
	art_assertions i_art_assertions (.pclk(pclk), .presetn(presetn), .reg_wr(tif.reg_wr),
		.reg_rd(tif.reg_rd), .reg_addr(tif.reg_addr), .reg_wdata(tif.reg_wdata),
		.reg_rdata(tif.reg_rdata), .narrow_en(tif.narrow_en), .irq_src(tif.irq_src),
		.freq_out(tif.freq_out));

	// ****************************************
	// Bench tasks
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int w;
		w = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			w++;
		end
		while (pready !== 1'b1 && w < 50);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (w >= 50)
		begin
			err_total++;
			summarize();
		end
	endtask

	// Waits for the next rising edge of an output and returns the cycles waited.
	task automatic edge_gap(input int k, input logic fq, output int g);
		logic p;
		logic v;
		p = 1'b1;
		v = 1'b1;
		g = 0;
		while (!(p === 1'b0 && v === 1'b1) && g < 5000)
		begin
			p = v;
			@(posedge pclk);
			g++;
			v = fq ? tif.freq_out[k] : tif.irq_src[k];
		end
		if (!(p === 1'b0 && v === 1'b1))
		begin
			err_total++;
			summarize();
		end
	endtask

	// The first gap after a load may be cut short by a pulse already scheduled, so use the third.
	task automatic period(input int k, input logic fq, input int r);
		int g;
		repeat (3) edge_gap(k, fq, g);
		chk(g, ART_IN_DIV[k] * (r + 1) * (fq ? 2 : 1));
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ART_OFS_ENABLE, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, ART_OFS_WIDE_COUNT, 32'h0);
		chk({8'h00, q[31:8]}, 32'h000000ff);
		apb(1'b0, 8'h14, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, ART_OFS_NARROW_LOAD, 32'h0);
		chk(q, 32'h0);
		$display("reset and map test done");
		apb(1'b1, ART_OFS_WIDE_LOAD, 32'h00000003);
		period(0, 1'b0, 3);
		period(0, 1'b1, 3);
		n = 2 + int'(rnd() % 8);
		apb(1'b1, ART_OFS_WIDE_LOAD, 32'(n));
		period(0, 1'b0, n);
		// Land the low byte one cycle before the next scheduled pulse.
		repeat (ART_IN_DIV[0] * (n + 1) - 7) @(posedge pclk);
		apb(1'b1, ART_OFS_WIDE_LOAD, 32'(n));
		edge_gap(0, 1'b0, gap);
		chk(32'(gap <= 4), 32'h1);
		apb(1'b0, ART_OFS_WIDE_COUNT, 32'h0);
		chk(32'(q[15:0] <= 16'(n)), 32'h1);
		$display("wide timer test done");
		for (int i = 0; i < ART_NUM_NARROW; i++)
		begin
			nar_n.push_back(1 + int'(rnd() % 5));
			apb(1'b1, ART_OFS_NARROW_LOAD, {22'h0, 2'(i), 8'(nar_n[i])});
		end
		chk({28'h0, tif.irq_src[4:1]}, 32'h0);
		apb(1'b1, ART_OFS_ENABLE, 32'h0000000f);
		apb(1'b0, ART_OFS_STATUS, 32'h0);
		chk({31'h0, q[ART_SETTLED_BIT]}, 32'h0);
		for (int i = 0; i < ART_NUM_NARROW; i++)
			period(i + 1, 1'b0, nar_n[i]);
		period(1, 1'b1, nar_n[0]);
		apb(1'b0, ART_OFS_ENABLE, 32'h0);
		chk(q, 32'h0000000f);
		$display("narrow enable test done");
		apb(1'b1, ART_OFS_ENABLE, 32'h0);
		repeat (ART_SETTLE_CYC + 2) @(posedge pclk);
		apb(1'b0, ART_OFS_STATUS, 32'h0);
		chk({31'h0, q[ART_SETTLED_BIT]}, 32'h1);
		chk({28'h0, q[4:1]}, 32'h0);
		apb(1'b1, ART_OFS_ENABLE, 32'h00000001);
		period(1, 1'b0, nar_n[0]);
		n = 1 + int'(rnd() % 5);
		apb(1'b1, ART_OFS_NARROW_LOAD, 32'(n));
		period(1, 1'b0, n);
		// Disable one cycle before the next scheduled pulse, reload in standby and
		// enable again: the stored pulse must come at the first input clock.
		repeat (ART_IN_DIV[1] * (n + 1) - 6) @(posedge pclk);
		apb(1'b1, ART_OFS_ENABLE, 32'h0);
		@(posedge pclk);
		chk({31'h0, tif.irq_src[1]}, 32'h1);
		apb(1'b1, ART_OFS_NARROW_LOAD, 32'h00000005);
		apb(1'b1, ART_OFS_ENABLE, 32'h00000001);
		edge_gap(1, 1'b0, gap);
		chk(32'(gap <= 10), 32'h1);
		$display("narrow disable and reload test done");
		summarize();
	end
endmodule
